// File: plw_pkg.sv
// constants and bus types for the bus parameter word loader
package plw_pkg;
   // register bus request carried as one group
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } plw_bus_req_t;

   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PARAM = 8'h08;
   localparam logic [7:0] REG_MEMBASE = 8'h0C;
   localparam logic [7:0] REG_GRANT = 8'h10;
   localparam logic [7:0] REG_LATENCY = 8'h14;
   localparam logic [7:0] REG_NODE0 = 8'h18;
   localparam logic [7:0] REG_NODE1 = 8'h1C;
   localparam logic [7:0] REG_NODE2 = 8'h20;

   // control and status bit positions
   localparam int CTRL_RELOAD = 0;
   localparam int CTRL_WAKE_CLR = 1;
   localparam int STAT_LOADED = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_WAKE = 2;

   // parameter word fields
   localparam int PW_WAKE_PULSE = 0;
   localparam int PW_LOW_MEG = 1;
   localparam int PW_WIN_OFF = 2;
   localparam int PW_GRANT_HI = 9;
   localparam int PW_GRANT_LO = 6;
   localparam int PW_LAT_HI = 15;
   localparam int PW_LAT_LO = 10;
   localparam logic [15:0] PARAM_DEFAULT = 16'h1540;

   // memory window base: writable address bits and map bit
   localparam int MEMBASE_LO = 7;
   localparam int MEMBASE_MAP_BIT = 1;

   // serial store word addresses
   localparam logic [7:0] EE_PARAM_ADDR = 8'h08;
   localparam logic [7:0] EE_NODE_ADDR = 8'h0A;
   localparam logic [1:0] FETCH_LAST = 2'h3;

   // wake pulse length
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WAKE_PULSE_US = 100;
   localparam int WAKE_PULSE_CYCLES = (WAKE_PULSE_US * 1000000) / CLK_PERIOD_PS;
   localparam int WAKE_CNT_W = 15;
endpackage

// File: plw_loader.sv
// bus parameter word loader: fetch, apply, register port, wake output
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Function
// - parameter bit 0 set makes the wake output a ~100 us pulse per event.
// - parameter bit 1 becomes the below-megabyte map bit of the memory window base.
// - parameter bit 2 set makes the memory window base read as all zeros.
// - parameter bits 9:6 are returned in bits 4:1 of the grant time value.
// - parameter bits 15:10 are returned in bits 5:0 of the latency limit.
// - parameter word is 1540h until the stored parameter word and all three node words have been read.
// - the three alternate node address words load the node address register.
module plw_loader #(
   parameter int unsigned WAKE_CYCLES = plw_pkg::WAKE_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire plw_pkg::plw_bus_req_t bus_req,
   output logic [31:0] rd_data,
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_valid,
   input wire logic [15:0] ee_data,
   input wire logic wake_event,
   output logic wake_signal,
   output logic [15:0] bus_parameter_word,
   output logic wake_pulse_select,
   output logic low_megabyte_map_cfg,
   output logic memory_window_off,
   output logic [7:0] grant_time_cfg,
   output logic [7:0] latency_limit_cfg,
   output logic [47:0] node_address_reg,
   output logic load_done
);
   import plw_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT} plw_state_t;

   plw_state_t state;
   logic [1:0] idx;
   logic [15:0] hold_param;
   logic [15:0] hold_node0;
   logic [15:0] hold_node1;
   logic [WAKE_CNT_W-1:0] wake_cnt;
   logic [31:7] membase;

   localparam logic [WAKE_CNT_W-1:0] WAKE_LEN = WAKE_CNT_W'(WAKE_CYCLES);

   // decode
   wire wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;
   wire reload_req = wr_ctrl && bus_req.wdata[CTRL_RELOAD];
   wire wake_clr = wr_ctrl && bus_req.wdata[CTRL_WAKE_CLR];
   wire wr_membase = bus_req.wr && bus_req.addr == REG_MEMBASE;
   wire wr_node0 = bus_req.wr && bus_req.addr == REG_NODE0;
   wire wr_node1 = bus_req.wr && bus_req.addr == REG_NODE1;
   wire wr_node2 = bus_req.wr && bus_req.addr == REG_NODE2;
   wire word_in = state == S_WAIT && ee_valid;
   wire last_in = word_in && idx == FETCH_LAST;
   wire [7:0] fetch_addr = (idx == 2'h0) ? EE_PARAM_ADDR : EE_NODE_ADDR + {6'h00, idx - 2'h1};
   wire busy = state != S_IDLE;

   // memory window base view; the map bit follows the parameter word
   wire [31:0] membase_view = memory_window_off ? 32'h0000_0000 :
      {membase, 5'h00, low_megabyte_map_cfg, 1'b0};

   wire [31:0] status_view = {29'h0000_0000, wake_signal, busy, load_done};
   wire [31:0] next_rd_data =
      (bus_req.addr == REG_STATUS) ? status_view :
      (bus_req.addr == REG_PARAM) ? {16'h0000, bus_parameter_word} :
      (bus_req.addr == REG_MEMBASE) ? membase_view :
      (bus_req.addr == REG_GRANT) ? {24'h00_0000, grant_time_cfg} :
      (bus_req.addr == REG_LATENCY) ? {24'h00_0000, latency_limit_cfg} :
      (bus_req.addr == REG_NODE0) ? {16'h0000, node_address_reg[47:32]} :
      (bus_req.addr == REG_NODE1) ? {16'h0000, node_address_reg[31:16]} :
      (bus_req.addr == REG_NODE2) ? {16'h0000, node_address_reg[15:0]} :
      32'h0000_0000;

   // fields derived from the word that is about to be applied
   wire [15:0] pw = hold_param;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 32'h0000_0000;
      end else if (ce) begin
         rd_data <= bus_req.rd ? next_rd_data : 32'h0000_0000;
      end
   end

   // fetch sequencer: starts by itself after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= S_REQ;
         idx <= 2'h0;
         ee_req <= 1'b0;
         ee_addr <= 8'h00;
         hold_param <= PARAM_DEFAULT;
         hold_node0 <= 16'h0000;
         hold_node1 <= 16'h0000;
      end else if (ce) begin
         ee_req <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (reload_req) begin
                  idx <= 2'h0;
                  state <= S_REQ;
               end
            end
            S_REQ: begin
               ee_req <= 1'b1;
               ee_addr <= fetch_addr;
               state <= S_WAIT;
            end
            S_WAIT: begin
               if (ee_valid) begin
                  if (idx == 2'h0) hold_param <= ee_data;
                  if (idx == 2'h1) hold_node0 <= ee_data;
                  if (idx == 2'h2) hold_node1 <= ee_data;
                  idx <= idx + 2'h1;
                  state <= (idx == FETCH_LAST) ? S_IDLE : S_REQ;
               end
            end
         endcase
      end
   end

   // outputs other than the bus-writable node address hold their reset values until the whole fetch completes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_parameter_word <= PARAM_DEFAULT;
         wake_pulse_select <= PARAM_DEFAULT[PW_WAKE_PULSE];
         low_megabyte_map_cfg <= PARAM_DEFAULT[PW_LOW_MEG];
         memory_window_off <= PARAM_DEFAULT[PW_WIN_OFF];
         grant_time_cfg <= {3'h0, PARAM_DEFAULT[PW_GRANT_HI:PW_GRANT_LO], 1'b0};
         latency_limit_cfg <= {2'h0, PARAM_DEFAULT[PW_LAT_HI:PW_LAT_LO]};
         node_address_reg <= 48'h0000_0000_0000;
         load_done <= 1'b0;
      end else if (ce) begin
         if (last_in) begin
            bus_parameter_word <= pw;
            wake_pulse_select <= pw[PW_WAKE_PULSE];
            low_megabyte_map_cfg <= pw[PW_LOW_MEG];
            memory_window_off <= pw[PW_WIN_OFF];
            grant_time_cfg <= {3'h0, pw[PW_GRANT_HI:PW_GRANT_LO], 1'b0};
            latency_limit_cfg <= {2'h0, pw[PW_LAT_HI:PW_LAT_LO]};
            node_address_reg <= {hold_node0, hold_node1, ee_data};
            load_done <= 1'b1;
         end else begin
            if (wr_node0) node_address_reg[47:32] <= bus_req.wdata[15:0];
            if (wr_node1) node_address_reg[31:16] <= bus_req.wdata[15:0];
            if (wr_node2) node_address_reg[15:0] <= bus_req.wdata[15:0];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         membase <= 25'h000_0000;
      end else if (ce && wr_membase) begin
         membase <= bus_req.wdata[31:MEMBASE_LO];
      end
   end

   // wake output: timed pulse, or a level that software clears (event wins)
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wake_cnt <= '0;
         wake_signal <= 1'b0;
      end else if (ce) begin
         if (wake_pulse_select) begin
            if (wake_event) begin
               wake_cnt <= WAKE_LEN;
               wake_signal <= 1'b1;
            end else if (wake_cnt != '0) begin
               wake_cnt <= wake_cnt - 1'b1;
               wake_signal <= wake_cnt != WAKE_CNT_W'(1);
            end else begin
               wake_signal <= 1'b0;
            end
         end else begin
            wake_cnt <= '0;
            if (wake_event) wake_signal <= 1'b1;
            else if (wake_clr) wake_signal <= 1'b0;
         end
      end
   end

   pulse_end_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && wake_pulse_select && !wake_event && wake_cnt == WAKE_CNT_W'(1) |=> !wake_signal)
      else $error("wake pulse did not end on count expiry");
   pulse_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      wake_pulse_select && wake_cnt > WAKE_CNT_W'(1) |-> wake_signal)
      else $error("wake pulse dropped early");
   level_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && !wake_pulse_select && wake_signal && !wake_clr |=> wake_signal)
      else $error("wake level dropped without clear");
   map_copy_a: assert property (@(posedge clk) disable iff (!resetn)
      low_megabyte_map_cfg == bus_parameter_word[PW_LOW_MEG])
      else $error("map bit differs from parameter word");
   window_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && bus_req.rd && bus_req.addr == REG_MEMBASE && memory_window_off |=> rd_data == 32'h0000_0000)
      else $error("disabled memory window read nonzero");
   grant_field_a: assert property (@(posedge clk) disable iff (!resetn)
      grant_time_cfg == {3'h0, bus_parameter_word[PW_GRANT_HI:PW_GRANT_LO], 1'b0})
      else $error("grant time field misplaced");
   latency_field_a: assert property (@(posedge clk) disable iff (!resetn)
      latency_limit_cfg == {2'h0, bus_parameter_word[PW_LAT_HI:PW_LAT_LO]})
      else $error("latency limit field misplaced");
   default_word_a: assert property (@(posedge clk) disable iff (!resetn)
      !load_done |-> bus_parameter_word == PARAM_DEFAULT)
      else $error("parameter word changed before load");
   node_load_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && last_in |=> node_address_reg[15:0] == $past(ee_data) && load_done)
      else $error("node address not loaded at fetch end");
   fetch_req_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && ee_req |=> !ee_req)
      else $error("fetch request longer than one cycle");
endmodule
`default_nettype wire

// File: plw_ee_model.sv
// serial store model answering one word request at a time
`timescale 1ns/1ps
`default_nettype none
module plw_ee_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   input wire logic [3:0] delay,
   output logic ee_valid,
   output logic [15:0] ee_data
);
   logic [15:0] mem [0:255];
   logic [3:0] cnt;
   logic busy;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         ee_valid <= 1'b0;
         ee_data <= 16'h0000;
      end else begin
         ee_valid <= 1'b0;
         // data line not held outside the answer cycle
         ee_data <= ~ee_data;
         if (ee_req) begin
            busy <= 1'b1;
            cnt <= delay;
         end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            ee_valid <= 1'b1;
            ee_data <= mem[ee_addr];
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: plw_loader_tb_top.sv
// self-checking bench for the bus parameter word loader
`timescale 1ns/1ps
`default_nettype none
module plw_loader_tb_top;
   import plw_pkg::*;
   localparam int WAKE_N = 8;
   typedef struct packed {
      logic [15:0] word;
      logic [7:0] grant;
      logic [7:0] lat;
   } plw_row_t;
   localparam plw_row_t ROWS [0:6] = '{'{16'hFFFF, 8'h1E, 8'h3F}, '{16'h0001, 8'h00, 8'h00},
      '{16'h0002, 8'h00, 8'h00}, '{16'h0004, 8'h00, 8'h00}, '{16'h03C0, 8'h1E, 8'h00},
      '{16'hFC00, 8'h00, 8'h3F}, '{16'h2940, 8'h0A, 8'h0A}};
   logic clk, resetn, ce, ee_req, ee_valid, wake_event, wake_signal, load_done;
   logic wake_pulse_select, low_megabyte_map_cfg, memory_window_off;
   plw_bus_req_t bus_req;
   logic [31:0] rd_data, d;
   logic [7:0] ee_addr, grant_time_cfg, latency_limit_cfg;
   logic [15:0] ee_data, bus_parameter_word, w;
   logic [47:0] node_address_reg;
   logic [3:0] delay;
   int error_cnt = 0, n_checks = 0, hi;

   plw_loader #(.WAKE_CYCLES(WAKE_N)) u_dut (.clk, .resetn, .ce, .bus_req, .rd_data, .ee_req, .ee_addr,
      .ee_valid, .ee_data, .wake_event, .wake_signal, .bus_parameter_word, .wake_pulse_select,
      .low_megabyte_map_cfg, .memory_window_off, .grant_time_cfg, .latency_limit_cfg, .node_address_reg, .load_done);
   plw_ee_model u_ee (.clk, .resetn, .ee_req, .ee_addr, .delay, .ee_valid, .ee_data);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk) bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk) bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk) bus_req.rd <= 1'b0;
      #1 v = rd_data;
   endtask

   // rerun the fetch with a new stored word and wait until it is applied
   task automatic load(input logic [15:0] v);
      logic [31:0] s;
      int n;
      u_ee.mem[8'h08] = v;
      wr(REG_CTRL, 32'h0000_0001);
      n = 0;
      do begin
         rd(REG_STATUS, s);
         n++;
      end while (s[STAT_BUSY] !== 1'b0 && n < 100);
      chk("fetch_end", 48'h0, 48'(s[STAT_BUSY]));
   endtask

   // wait for the autonomous fetch after reset; a run-out counts as a mismatch
   task automatic wait_done;
      int n;
      n = 0;
      while (load_done !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      chk("load_done", 48'h1, 48'(load_done));
   endtask

   initial begin
      #(5 * 20000);
      error_cnt++;
      test_done();
   end

   initial begin
      ce = 1'b1;
      wake_event = 1'b0;
      bus_req = '0;
      delay = 4'hA;
      resetn = 1'b0;
      u_ee.mem[8'h08] = 16'h2940;
      u_ee.mem[8'h0A] = 16'h0123;
      u_ee.mem[8'h0B] = 16'h4567;
      u_ee.mem[8'h0C] = 16'h89AB;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("param_default", 48'(PARAM_DEFAULT), 48'(bus_parameter_word));
      chk("grant_default", 48'h0A, 48'(grant_time_cfg));
      chk("lat_default", 48'h05, 48'(latency_limit_cfg));
      chk("done_early", 48'h0, 48'(load_done));
      wait_done();
      chk("node", 48'h0123_4567_89AB, node_address_reg);
      chk("param_fetched", 48'h2940, 48'(bus_parameter_word));
      $display("reset and fetch test done");
      delay = 4'h0;
      wr(REG_MEMBASE, 32'hFFFF_FF80);
      for (int r = 0; r < 7; r++) begin
         w = ROWS[r].word;
         load(w);
         chk("param", 48'(w), 48'(bus_parameter_word));
         chk("wake_sel", 48'(w[0]), 48'(wake_pulse_select));
         chk("low_map", 48'(w[1]), 48'(low_megabyte_map_cfg));
         chk("win_off", 48'(w[2]), 48'(memory_window_off));
         chk("grant", 48'(ROWS[r].grant), 48'(grant_time_cfg));
         chk("latency", 48'(ROWS[r].lat), 48'(latency_limit_cfg));
         rd(REG_MEMBASE, d);
         chk("membase", w[2] ? 48'h0 : 48'(32'hFFFF_FF80 | {30'h0, w[1], 1'b0}), 48'(d));
         rd(REG_GRANT, d);
         chk("grant_reg", 48'(ROWS[r].grant), 48'(d));
         rd(REG_LATENCY, d);
         chk("lat_reg", 48'(ROWS[r].lat), 48'(d));
      end
      $display("parameter table test done");
      // m 0: level, m 1: pulse, m 2: pulse with clock enable held low mid-pulse
      for (int m = 0; m < 3; m++) begin
         load(m ? 16'h0001 : 16'h0000);
         @(posedge clk) wake_event <= 1'b1;
         @(posedge clk) begin
            wake_event <= 1'b0;
            ce <= (m != 2);
         end
         if (m == 2) begin
            repeat (10) @(posedge clk);
            #1 chk("ce_freeze", 48'h1, 48'(wake_signal));
            @(posedge clk) ce <= 1'b1;
         end
         hi = 0;
         repeat (20) begin
            #1 hi += (wake_signal === 1'b1);
            @(posedge clk);
         end
         chk("wake_len", m ? 48'(WAKE_N) : 48'd20, 48'(hi));
         if (m == 0) begin
            // event and clear in the same cycle: the event wins
            @(posedge clk) begin
               wake_event <= 1'b1;
               bus_req <= '{addr: REG_CTRL, wdata: 32'h0000_0002, wr: 1'b1, rd: 1'b0};
            end
            @(posedge clk) begin
               wake_event <= 1'b0;
               bus_req.wr <= 1'b0;
            end
            #1 chk("event_wins", 48'h1, 48'(wake_signal));
         end
         wr(REG_CTRL, 32'h0000_0002);
         #1 chk("wake_clear", 48'h0, 48'(wake_signal));
      end
      rd(8'hFC, d);
      chk("unmapped", 48'h0, 48'(d));
      $display("wake and unmapped test done");
      wr(REG_NODE1, 32'h0000_BEEF);
      rd(REG_NODE1, d);
      chk("node_wr", 48'hBEEF, 48'(d));
      chk("node_reg", 48'h0123_BEEF_89AB, node_address_reg);
      // second reset in mid-run: defaults held, fetch restarts by itself
      @(posedge clk) resetn <= 1'b0;
      @(posedge clk) resetn <= 1'b1;
      @(posedge clk);
      #1 chk("reset_param", 48'(PARAM_DEFAULT), 48'(bus_parameter_word));
      chk("reset_node", 48'h0, node_address_reg);
      chk("reset_done", 48'h0, 48'(load_done));
      chk("fetch_req", 48'h1, 48'(ee_req));
      chk("fetch_addr", 48'h08, 48'(ee_addr));
      wait_done();
      chk("refetch", 48'h0001, 48'(bus_parameter_word));
      $display("node write and reset test done");
      test_done();
   end
endmodule
`default_nettype wire
